// >>> dv/fieldbus_master_model.sv
// Fieldbus master model: sends one cyclic frame per call of send.
// Assumes the bench calls send from its own process; frames are clocked by core_clk_in.
`timescale 1ns/1ps
module fieldbus_master_model
(
	input wire logic core_clk_in,
	output logic frame_valid_out,
	output drive_pkg::frame_t frame_out
);
	initial
	begin
		frame_valid_out = 1'b0;
		frame_out = 32'h0;
	end

	// One frame: control word and setpoint travel together
	task automatic send(input logic [15:0] cw, input logic [15:0] sp);
		@(posedge core_clk_in);
		frame_valid_out <= 1'b1;
		frame_out <= {cw, sp};
		@(posedge core_clk_in);
		frame_valid_out <= 1'b0;
		// Released frame shows the inverse of the last value
		frame_out <= ~{cw, sp};
		#1;
	endtask
endmodule

// >>> dv/tb_drive_state_machine.sv
// Self-checking testbench of the drive operating-state machine.
// Assumes the design package, the design and the fieldbus master model are compiled first.
`timescale 1ns/1ps
module tb_drive_state_machine;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ce_in = 1'b1;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] reg_rdata_out;
	logic frame_valid;
	drive_pkg::frame_t frame;
	logic comm_active_in = 1'b1;
	logic master_run_in = 1'b1;
	logic cmd_source_in = 1'b1;
	logic drive_enabled_in = 1'b1;
	logic drive_fault_in = 1'b0;
	logic [15:0] fault_code_in = 16'h0;
	logic network_mode_in = 1'b1;
	logic emergency_drive_in = 1'b0;
	logic commercial_supply_in = 1'b0;
	logic motor_stopped_in = 1'b0;
	logic output_stop_input_in = 1'b0;
	logic preexcitation_input_in = 1'b0;
	drive_pkg::drive_cmd_t cmd;
	logic ready;
	logic [15:0] status_word;
	logic [15:0] decel_time;
	logic [15:0] stop_torque;
	int err_count = 0;
	int checks = 0;

	always #2 core_clk_in = ~core_clk_in;

	fieldbus_master_model master
	(
		.core_clk_in(core_clk_in),
		.frame_valid_out(frame_valid),
		.frame_out(frame)
	);

	drive_state_machine dut
	(
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out),
		.frame_valid_in(frame_valid),
		.frame_in(frame),
		.comm_active_in(comm_active_in),
		.master_run_in(master_run_in),
		.cmd_source_in(cmd_source_in),
		.drive_enabled_in(drive_enabled_in),
		.drive_fault_in(drive_fault_in),
		.fault_code_in(fault_code_in),
		.network_mode_in(network_mode_in),
		.emergency_drive_in(emergency_drive_in),
		.commercial_supply_in(commercial_supply_in),
		.motor_stopped_in(motor_stopped_in),
		.output_stop_input_in(output_stop_input_in),
		.preexcitation_input_in(preexcitation_input_in),
		.drive_cmd_out(cmd),
		.drive_ready_output_out(ready),
		.status_word_out(status_word),
		.quick_decel_time_setting_out(decel_time),
		.quick_stop_torque_setting_out(stop_torque)
	);

	task automatic cmp_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
		#1;
	endtask

	task automatic chk_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		cmp_val(name, exp, reg_rdata_out);
	endtask

	task automatic chk_state(input drive_pkg::state_t s);
		@(posedge core_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= drive_pkg::REG_STATUS;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		cmp_val("state", {29'h0, s}, {29'h0, reg_rdata_out[18:16]});
		cmp_val("status_read", {16'h0, status_word}, {16'h0, reg_rdata_out[15:0]});
	endtask

	task automatic t_freeze;
		@(posedge core_clk_in);
		ce_in <= 1'b0;
		master.send(16'h0006, 16'h0000);
		reg_wr(drive_pkg::REG_QSTOP, 32'h0);
		@(posedge core_clk_in);
		ce_in <= 1'b1;
		cmp_val("decel", 16'h0100, decel_time);
		chk_state(drive_pkg::state_inhibited);
	endtask

	task automatic settle;
		repeat (2) @(posedge core_clk_in);
		#1;
	endtask

	task automatic to_op;
		master.send(16'h0006, 16'h0000);
		master.send(16'h0007, 16'h0000);
		master.send(16'h000f, 16'h0010);
	endtask

	task automatic t_reset;
		cmp_val("ready", 1'h0, ready);
		cmp_val("output_off", 1'h1, cmd.output_off);
		chk_state(drive_pkg::state_inhibited);
		chk_reg("ctrl", drive_pkg::REG_CTRL, 32'h0);
		chk_reg("qstop", drive_pkg::REG_QSTOP, 32'h0);
		chk_reg("unmapped", 8'h14, 32'h0);
	endtask

	task automatic t_walk;
		@(posedge core_clk_in);
		cmd_source_in <= 1'b0;
		master.send(16'h0006, 16'h0000);
		chk_state(drive_pkg::state_inhibited);
		@(posedge core_clk_in);
		cmd_source_in <= 1'b1;
		master.send(16'h0006, 16'h0000);
		chk_state(drive_pkg::state_ready);
		cmp_val("ready", 1'h0, ready);
		cmp_val("output_off", 1'h1, cmd.output_off);
		master.send(16'h0007, 16'h0000);
		cmp_val("ready", 1'h1, ready);
		cmp_val("output_off", 1'h0, cmd.output_off);
		cmp_val("start", 1'h0, cmd.start_cmd);
		@(posedge core_clk_in);
		output_stop_input_in <= 1'b1;
		settle;
		cmp_val("ready", 1'h0, ready);
		@(posedge core_clk_in);
		output_stop_input_in <= 1'b0;
		drive_enabled_in <= 1'b0;
		master.send(16'h000f, 16'h0010);
		chk_state(drive_pkg::state_switched_on);
		@(posedge core_clk_in);
		drive_enabled_in <= 1'b1;
		master.send(16'h100f, 16'h0010);
		chk_state(drive_pkg::state_operation);
		cmp_val("start", 1'h1, cmd.start_cmd);
		cmp_val("reverse", 1'h1, cmd.reverse_dir);
		@(posedge core_clk_in);
		output_stop_input_in <= 1'b1;
		master.send(16'h0007, 16'h0000);
		chk_state(drive_pkg::state_switched_on);
		cmp_val("start", 1'h0, cmd.start_cmd);
		@(posedge core_clk_in);
		output_stop_input_in <= 1'b0;
	endtask

	task automatic t_ramp;
		master.send(16'h000f, 16'h0010);
		cmp_val("reverse", 1'h0, cmd.reverse_dir);
		master.send(16'h0006, 16'h0000);
		chk_state(drive_pkg::state_ramp_stop);
		cmp_val("start", 1'h0, cmd.start_cmd);
		cmp_val("ramp", 1'h1, cmd.ramp_stop);
		@(posedge core_clk_in);
		motor_stopped_in <= 1'b1;
		settle;
		chk_state(drive_pkg::state_ready);
		@(posedge core_clk_in);
		motor_stopped_in <= 1'b0;
	endtask

	task automatic t_quick;
		reg_wr(drive_pkg::REG_QSTOP, 32'h0020_0100);
		cmp_val("decel", 16'h0100, decel_time);
		cmp_val("torque", 16'h0020, stop_torque);
		master.send(16'h0007, 16'h0000);
		master.send(16'h000f, 16'h0010);
		master.send(16'h000b, 16'h0010);
		chk_state(drive_pkg::state_quick_stop);
		cmp_val("start", 1'h0, cmd.start_cmd);
		cmp_val("quick", 1'h1, cmd.quick_stop);
		@(posedge core_clk_in);
		motor_stopped_in <= 1'b1;
		settle;
		chk_state(drive_pkg::state_inhibited);
		@(posedge core_clk_in);
		motor_stopped_in <= 1'b0;
	endtask

	task automatic t_comm(input logic [1:0] a);
		reg_wr(drive_pkg::REG_CTRL, {30'h0, a});
		to_op;
		@(posedge core_clk_in);
		comm_active_in <= 1'b0;
		settle;
		if (a == 2'h0)
		begin
			chk_state(drive_pkg::state_operation);
		end
		else
		begin
			chk_state(drive_pkg::state_fault_stop);
			cmp_val("fault_bit", 1'h1, status_word[drive_pkg::SW_FAULT]);
			if (a == drive_pkg::CEA_STOP)
			begin
				master.send(16'h000b, 16'h0010);
				chk_state(drive_pkg::state_fault_stop);
			end
		end
		@(posedge core_clk_in);
		comm_active_in <= 1'b1;
		settle;
		if (a == drive_pkg::CEA_STOP)
		begin
			chk_state(drive_pkg::state_fault_stop);
			master.send(16'h000b, 16'h0010);
			chk_state(drive_pkg::state_quick_stop);
		end
		else
		begin
			chk_state(drive_pkg::state_operation);
		end
		master.send(16'h0005, 16'h0000);
		chk_state(drive_pkg::state_inhibited);
	endtask

	task automatic t_forced;
		to_op;
		@(posedge core_clk_in);
		fault_code_in <= 16'h00a5;
		drive_fault_in <= 1'b1;
		settle;
		chk_state(drive_pkg::state_inhibited);
		cmp_val("fault_bit", 1'h1, status_word[drive_pkg::SW_FAULT]);
		@(posedge core_clk_in);
		drive_fault_in <= 1'b0;
		reg_wr(drive_pkg::REG_FAULT_SEL, 32'h0);
		chk_reg("fault_code", drive_pkg::REG_FAULT_CODE, 32'h0000_00a5);
		to_op;
		@(posedge core_clk_in);
		network_mode_in <= 1'b0;
		settle;
		chk_state(drive_pkg::state_inhibited);
		@(posedge core_clk_in);
		network_mode_in <= 1'b1;
		to_op;
		@(posedge core_clk_in);
		master_run_in <= 1'b0;
		settle;
		chk_state(drive_pkg::state_inhibited);
		@(posedge core_clk_in);
		master_run_in <= 1'b1;
		emergency_drive_in <= 1'b1;
		settle;
		chk_state(drive_pkg::state_operation);
		@(posedge core_clk_in);
		commercial_supply_in <= 1'b1;
		settle;
		chk_state(drive_pkg::state_inhibited);
		@(posedge core_clk_in);
		emergency_drive_in <= 1'b0;
		commercial_supply_in <= 1'b0;
	endtask

	task automatic t_posctl;
		reg_wr(drive_pkg::REG_CTRL, 32'h4);
		preexcitation_input_in <= 1'b1;
		to_op;
		cmp_val("servo_on", 1'h1, cmd.servo_on);
		cmp_val("preexcite", 1'h0, cmd.preexcite);
		master.send(16'h0006, 16'h0000);
		chk_state(drive_pkg::state_ramp_stop);
		cmp_val("servo_on", 1'h0, cmd.servo_on);
		cmp_val("output_off", 1'h1, cmd.output_off);
		cmp_val("start", 1'h0, cmd.start_cmd);
	endtask

	task automatic complete_run;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		settle;
		t_reset;
		t_walk;
		t_ramp;
		t_quick;
		t_comm(drive_pkg::CEA_STOP);
		t_comm(drive_pkg::CEA_STOP_RESUME);
		t_comm(2'h0);
		t_forced;
		t_freeze;
		t_posctl;
		complete_run;
	end

	initial
	begin
		#100000;
		err_count++;
		complete_run;
	end
endmodule

// >>> logic/drive_pkg.sv
// Shared types and constants of the drive operating-state machine.
// Assumes one clock domain and a plain register port owned by the core.
package drive_pkg;
	typedef enum logic [2:0] {
		state_inhibited,
		state_ready,
		state_switched_on,
		state_operation,
		state_ramp_stop,
		state_quick_stop,
		state_fault_stop
	} state_t;

	// Cyclic frame from the master
	typedef struct packed {
		logic [15:0] control_word;
		logic [15:0] speed_setpoint;
	} frame_t;

	// Drive command bundle toward the power stage
	typedef struct packed {
		logic start_cmd;
		logic reverse_dir;
		logic servo_on;
		logic output_off;
		logic ramp_stop;
		logic quick_stop;
		logic fault_stop;
		logic preexcite;
	} drive_cmd_t;

	// Control word fields
	localparam int CW_SWITCH_ON = 0;
	localparam int CW_NO_COAST = 1;
	localparam int CW_NO_QUICK = 2;
	localparam int CW_ENABLE_OP = 3;
	localparam int CW_DIR_SEL = 12;
	localparam int SP_SIGN = 15;

	// Status word fields
	localparam int SW_READY_ON = 0;
	localparam int SW_SWITCHED_ON = 1;
	localparam int SW_OP_ENABLED = 2;
	localparam int SW_FAULT = 3;
	localparam int SW_NO_COAST = 4;
	localparam int SW_NO_QUICK = 5;
	localparam int SW_INHIBITED = 6;
	localparam int SW_CTRL_REQ = 9;

	// Communication-error action codes
	localparam logic [1:0] CEA_STOP = 2'h1;
	localparam logic [1:0] CEA_STOP_RESUME = 2'h2;

	// Register map (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_QSTOP = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_FAULT_SEL = 8'h0c;
	localparam logic [7:0] REG_FAULT_CODE = 8'h10;

	// Control register fields and reset value
	localparam int CTRL_CEA_LSB = 0;
	localparam int CTRL_POSCTL = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [31:0] QSTOP_RESET = 32'h0;

	// Status register fields
	localparam int STAT_WORD_LSB = 0;
	localparam int STAT_STATE_LSB = 16;

	// Fault history
	localparam int FAULT_DEPTH = 8;
	localparam int FAULT_IDX_W = 3;
	localparam logic [FAULT_IDX_W-1:0] FAULT_LAST = 3'h7;
endpackage

// >>> logic/drive_state_machine.sv
// Operating-state machine of a fieldbus-controlled motor drive, with its register port.
// Assumes synchronous inputs on core_clk_in and one frame-valid pulse per cyclic frame.
// Functional notes
// - Power-up enters inhibited state; output shut off, ready low.
// - Ready state stays stopped with output shut off and ready low.
// - Switched-on state releases shutoff and raises ready; motor stays stopped.
// - Output-stop or other shutoff keeps ready low in every state.
// - Operation asserts start command with direction from word and setpoint; servo-on if positioning.
// - Ramp stop drops start and decelerates; positioning goes servo-off with shutoff.
// - Fault stop is entered only with error action 1 or 2.
// - Fault, non-network mode, commercial supply in emergency, master stop in operation or a stop state force inhibited.
// - Emergency drive forces operation regardless of control-word commands; forced-inhibit conditions above win over it, master stop only once in operation.
// - Positioning switches servo with state and ignores pre-excitation input.
// - OFF is ignored unless the master is the command source.
// - Enable operation is ignored unless the drive is enabled.
// - Disable operation acts even with ready low; drops start and servo-on.
// - Master stop overrides the motor-stop transition; ramp stop then goes to inhibited, not ready.
// - Communication loss in operation, ramp stop or quick stop with action 1 or 2 leads to fault stop.
// - Communication restart leaves fault stop only with action 2.
// - With action 1, quick stop leaves fault stop only after restart.
// - Word 110 OFF, 111 ON, bit3 enable, bit2 low quick, bit1 low coast.
// - Fault state sets status bit 3 and logs the fault code.
`timescale 1ns/1ps
module drive_state_machine
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic frame_valid_in,
	input wire drive_pkg::frame_t frame_in,
	input wire logic comm_active_in,
	input wire logic master_run_in,
	input wire logic cmd_source_in,
	input wire logic drive_enabled_in,
	input wire logic drive_fault_in,
	input wire logic [15:0] fault_code_in,
	input wire logic network_mode_in,
	input wire logic emergency_drive_in,
	input wire logic commercial_supply_in,
	input wire logic motor_stopped_in,
	input wire logic output_stop_input_in,
	input wire logic preexcitation_input_in,
	output drive_pkg::drive_cmd_t drive_cmd_out,
	output logic drive_ready_output_out,
	output logic [15:0] status_word_out,
	output logic [15:0] quick_decel_time_setting_out,
	output logic [15:0] quick_stop_torque_setting_out
);
	drive_pkg::state_t state_r, state_nxt, resume_r;
	logic [drive_pkg::CTRL_POSCTL:0] ctrl_r;
	logic [31:0] qstop_r;
	logic [drive_pkg::FAULT_IDX_W-1:0] fault_sel_r;
	logic [31:0] rdata_r;
	logic comm_prev_r, restarted_r, fault_prev_r, dir_r;
	logic [15:0] hist_code;

	wire [1:0] cea = ctrl_r[drive_pkg::CTRL_CEA_LSB +: 2];
	wire posctl = ctrl_r[drive_pkg::CTRL_POSCTL];
	wire [15:0] cw = frame_in.control_word;
	wire cmd_valid = frame_valid_in;
	wire cw_coast = !cw[drive_pkg::CW_NO_COAST];
	wire cw_quick = cw[drive_pkg::CW_NO_COAST] && !cw[drive_pkg::CW_NO_QUICK];
	wire cw_run = cw[drive_pkg::CW_NO_COAST] && cw[drive_pkg::CW_NO_QUICK];
	wire cw_off = cw_run && !cw[drive_pkg::CW_SWITCH_ON];
	wire cw_on = cw_run && cw[drive_pkg::CW_SWITCH_ON];
	wire cw_enable = cw_on && cw[drive_pkg::CW_ENABLE_OP];
	wire cw_disable = cw_on && !cw[drive_pkg::CW_ENABLE_OP];
	wire cea_active = (cea == drive_pkg::CEA_STOP) || (cea == drive_pkg::CEA_STOP_RESUME);
	wire comm_lost = comm_prev_r && !comm_active_in;
	wire comm_back = !comm_prev_r && comm_active_in;
	wire running = state_r == drive_pkg::state_operation || state_r == drive_pkg::state_ramp_stop ||
		state_r == drive_pkg::state_quick_stop || state_r == drive_pkg::state_fault_stop;
	wire force_inhibit = drive_fault_in || !network_mode_in ||
		(emergency_drive_in && commercial_supply_in) || (!master_run_in && running);
	wire fault_new = drive_fault_in && !fault_prev_r;
	wire in_fault = drive_fault_in || state_r == drive_pkg::state_fault_stop;

	// Transition logic
	always_comb
	begin
		state_nxt = state_r;
		if (force_inhibit)
			state_nxt = drive_pkg::state_inhibited;
		else if (emergency_drive_in)
			state_nxt = drive_pkg::state_operation;
		else
		begin
			unique case (state_r)
				drive_pkg::state_inhibited:
					if (cmd_valid && cw_off && cmd_source_in)
						state_nxt = drive_pkg::state_ready;
				drive_pkg::state_ready:
					if (cmd_valid && (cw_coast || cw_quick))
						state_nxt = drive_pkg::state_inhibited;
					else if (cmd_valid && cw_on)
						state_nxt = drive_pkg::state_switched_on;
				drive_pkg::state_switched_on:
					if (cmd_valid && (cw_coast || cw_quick))
						state_nxt = drive_pkg::state_inhibited;
					else if (cmd_valid && cw_off && cmd_source_in)
						state_nxt = drive_pkg::state_ready;
					else if (cmd_valid && cw_enable && drive_enabled_in)
						state_nxt = drive_pkg::state_operation;
				drive_pkg::state_operation:
					if (comm_lost && cea_active)
						state_nxt = drive_pkg::state_fault_stop;
					else if (cmd_valid && cw_coast)
						state_nxt = drive_pkg::state_inhibited;
					else if (cmd_valid && cw_quick)
						state_nxt = drive_pkg::state_quick_stop;
					else if (cmd_valid && cw_off && cmd_source_in)
						state_nxt = drive_pkg::state_ramp_stop;
					else if (cmd_valid && cw_disable)
						state_nxt = drive_pkg::state_switched_on;
				drive_pkg::state_ramp_stop:
					if (comm_lost && cea_active)
						state_nxt = drive_pkg::state_fault_stop;
					else if (motor_stopped_in)
						state_nxt = drive_pkg::state_ready;
					else if (cmd_valid && cw_coast)
						state_nxt = drive_pkg::state_inhibited;
					else if (cmd_valid && cw_quick)
						state_nxt = drive_pkg::state_quick_stop;
					else if (cmd_valid && cw_enable && drive_enabled_in)
						state_nxt = drive_pkg::state_operation;
				drive_pkg::state_quick_stop:
					if (comm_lost && cea_active)
						state_nxt = drive_pkg::state_fault_stop;
					else if (motor_stopped_in)
						state_nxt = drive_pkg::state_inhibited;
					else if (cmd_valid && cw_coast)
						state_nxt = drive_pkg::state_inhibited;
				drive_pkg::state_fault_stop:
					if (comm_back && cea == drive_pkg::CEA_STOP_RESUME)
						state_nxt = resume_r;
					else if (motor_stopped_in)
						state_nxt = drive_pkg::state_inhibited;
					else if (cmd_valid && cw_quick && cea == drive_pkg::CEA_STOP && restarted_r)
						state_nxt = drive_pkg::state_quick_stop;
					else if (cmd_valid && cw_coast)
						state_nxt = drive_pkg::state_inhibited;
				default:
					state_nxt = drive_pkg::state_inhibited;
			endcase
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
			state_r <= drive_pkg::state_inhibited;
		else if (ce_in)
			state_r <= state_nxt;
	end

	// Communication tracking and return state for restart
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			comm_prev_r <= 1'b1;
			fault_prev_r <= 1'b0;
			restarted_r <= 1'b0;
			dir_r <= 1'b0;
			resume_r <= drive_pkg::state_inhibited;
		end
		else if (ce_in)
		begin
			comm_prev_r <= comm_active_in;
			if (cmd_valid)
				dir_r <= cw[drive_pkg::CW_DIR_SEL] ^ frame_in.speed_setpoint[drive_pkg::SP_SIGN];
			fault_prev_r <= drive_fault_in;
			if (state_r != drive_pkg::state_fault_stop)
				resume_r <= state_r;
			if (comm_back)
				restarted_r <= 1'b1;
			else if (state_nxt == drive_pkg::state_fault_stop && state_r != drive_pkg::state_fault_stop)
				restarted_r <= 1'b0;
		end
	end

	// Drive command outputs
	wire st_op = state_r == drive_pkg::state_operation;
	wire st_ramp = state_r == drive_pkg::state_ramp_stop;
	wire st_quick = state_r == drive_pkg::state_quick_stop;
	wire st_stopped = state_r == drive_pkg::state_inhibited || state_r == drive_pkg::state_ready;
	wire shutoff = st_stopped || output_stop_input_in || (posctl && (st_ramp || st_quick));

	assign drive_cmd_out.start_cmd = st_op;
	assign drive_cmd_out.reverse_dir = st_op && dir_r;
	assign drive_cmd_out.servo_on = posctl && st_op;
	assign drive_cmd_out.output_off = shutoff;
	assign drive_cmd_out.ramp_stop = st_ramp && !posctl;
	assign drive_cmd_out.quick_stop = st_quick && !posctl;
	assign drive_cmd_out.fault_stop = state_r == drive_pkg::state_fault_stop;
	assign drive_cmd_out.preexcite = preexcitation_input_in && !posctl;
	assign drive_ready_output_out = !shutoff && (state_r == drive_pkg::state_switched_on || st_op);
	assign quick_decel_time_setting_out = qstop_r[15:0];
	assign quick_stop_torque_setting_out = qstop_r[31:16];

	// Status word
	always_comb
	begin
		status_word_out = '0;
		status_word_out[drive_pkg::SW_READY_ON] = !st_stopped || state_r == drive_pkg::state_ready;
		status_word_out[drive_pkg::SW_SWITCHED_ON] = state_r == drive_pkg::state_switched_on || st_op;
		status_word_out[drive_pkg::SW_OP_ENABLED] = st_op;
		status_word_out[drive_pkg::SW_FAULT] = in_fault;
		status_word_out[drive_pkg::SW_NO_COAST] = !shutoff;
		status_word_out[drive_pkg::SW_NO_QUICK] = !st_quick;
		status_word_out[drive_pkg::SW_INHIBITED] = state_r == drive_pkg::state_inhibited;
		status_word_out[drive_pkg::SW_CTRL_REQ] = cmd_source_in;
	end

	fault_history u_hist
	(
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.store_in(fault_new),
		.code_in(fault_code_in),
		.sel_in(fault_sel_r),
		.code_out(hist_code)
	);

	// Register port
	wire wr_ctrl = reg_wr_in && reg_addr_in == drive_pkg::REG_CTRL;
	wire wr_qstop = reg_wr_in && reg_addr_in == drive_pkg::REG_QSTOP;
	wire wr_sel = reg_wr_in && reg_addr_in == drive_pkg::REG_FAULT_SEL;
	wire [31:0] stat_word = {13'h0, state_r, status_word_out};
	wire [31:0] rd_mux =
		reg_addr_in == drive_pkg::REG_CTRL ? {29'h0, ctrl_r} :
		reg_addr_in == drive_pkg::REG_QSTOP ? qstop_r :
		reg_addr_in == drive_pkg::REG_STATUS ? stat_word :
		reg_addr_in == drive_pkg::REG_FAULT_SEL ? {29'h0, fault_sel_r} :
		reg_addr_in == drive_pkg::REG_FAULT_CODE ? {16'h0, hist_code} : 32'h0;

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			ctrl_r <= drive_pkg::CTRL_RESET;
			qstop_r <= drive_pkg::QSTOP_RESET;
			fault_sel_r <= '0;
			rdata_r <= '0;
		end
		else if (ce_in)
		begin
			if (wr_ctrl)
				ctrl_r <= reg_wdata_in[drive_pkg::CTRL_POSCTL:0];
			if (wr_qstop)
				qstop_r <= reg_wdata_in;
			if (wr_sel)
				fault_sel_r <= reg_wdata_in[drive_pkg::FAULT_IDX_W-1:0];
			rdata_r <= reg_rd_in ? rd_mux : 32'h0;
		end
	end

	assign reg_rdata_out = rdata_r;

	// Checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_lost_in_op;
		ce_in && st_op && comm_lost && cea_active && !force_inhibit && !emergency_drive_in;
	endsequence
	sequence s_in_fault_stop;
		state_r == drive_pkg::state_fault_stop;
	endsequence

	chk_reset_inhibited: assert property (disable iff (1'b0) !rst_n_in |=> state_r == drive_pkg::state_inhibited)
		else $error("state not inhibited after reset");
	chk_ready_low_stopped: assert property (st_stopped |-> !drive_ready_output_out && drive_cmd_out.output_off)
		else $error("ready or output active while stopped");
	chk_ready_switched: assert property (state_r == drive_pkg::state_switched_on && !output_stop_input_in
		|-> drive_ready_output_out)
		else $error("ready missing in switched on");
	chk_stop_input_ready: assert property (output_stop_input_in |-> !drive_ready_output_out)
		else $error("ready high under output stop");
	chk_force_inhibit: assert property (ce_in && force_inhibit |=> state_r == drive_pkg::state_inhibited)
		else $error("forced inhibit not taken");
	chk_emergency_op: assert property (ce_in && emergency_drive_in && !force_inhibit
		|=> st_op && drive_cmd_out.start_cmd)
		else $error("emergency drive did not force operation");
	chk_lost_fault_stop: assert property (s_lost_in_op |=> s_in_fault_stop)
		else $error("communication loss did not enter fault stop");
	chk_fault_needs_cea: assert property ($rose(state_r == drive_pkg::state_fault_stop) |-> $past(cea_active))
		else $error("fault stop without error action");
	chk_off_source: assert property (ce_in && state_r == drive_pkg::state_inhibited && !cmd_source_in
		&& !emergency_drive_in |=> state_r == drive_pkg::state_inhibited)
		else $error("OFF acted without command source");
	chk_servo_state: assert property (posctl && !st_op |-> !drive_cmd_out.servo_on && !drive_cmd_out.preexcite)
		else $error("servo on outside operation");
	chk_read_data: assert property (ce_in && reg_rd_in && reg_addr_in == drive_pkg::REG_STATUS
		|=> reg_rdata_out[15:0] == $past(status_word_out))
		else $error("status read mismatch");
endmodule

// >>> logic/fault_history.sv
// Fault history list: keeps up to eight fault codes in arrival order.
// Assumes a one-cycle store pulse from the state core.
`timescale 1ns/1ps
module fault_history
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic store_in,
	input wire logic [15:0] code_in,
	input wire logic [drive_pkg::FAULT_IDX_W-1:0] sel_in,
	output logic [15:0] code_out
);
	logic [15:0] entry_r [drive_pkg::FAULT_DEPTH];
	logic [drive_pkg::FAULT_IDX_W-1:0] fill_r;
	logic full_r;
	logic [drive_pkg::FAULT_IDX_W-1:0] wr_idx;

	// Once full, the newest fault overwrites the last slot
	assign wr_idx = full_r ? drive_pkg::FAULT_LAST : fill_r;
	assign code_out = entry_r[sel_in];

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			fill_r <= '0;
			full_r <= 1'b0;
		end
		else if (ce_in && store_in && !full_r)
		begin
			fill_r <= fill_r + 1'b1;
			full_r <= (fill_r == drive_pkg::FAULT_LAST);
		end
	end

	for (genvar i = 0; i < drive_pkg::FAULT_DEPTH; i++)
	begin : g_entry
		always_ff @(posedge core_clk_in)
		begin
			if (!rst_n_in)
				entry_r[i] <= '0;
			else if (ce_in && store_in && wr_idx == i)
				entry_r[i] <= code_in;
		end
	end
endmodule
